// *** core/ictm_pkg.sv ***
// Contract
// - A zero-wait read or write bus cycle lasts four clock periods.
// - A slow memory stretches the cycle; each wait state adds one period.
// - Total periods cover the opcode fetch plus every operand read and write.
// - Periods outside read or write cycles are bus idle, spent internally.
// - Effective address calculation uses read cycles only, never a write.
// - Address calculation counts extension fetches, address forming and operand read.
// - (An) and (An)+: 4(1/0), long 8(2/0); no fetch 2(0/0), 4(0/0).
// - -(An): 6(1/0), long 10(2/0); no fetch 4(0/0).
// - (d16,An): 8(2/0), long 12(3/0); no fetch 4(0/0), long 4(1/0).
// - (d8,An,Xn): 10(2/0), long 14(3/0); no fetch 8(1/0).
// - (d16,PC): 8(2/0), long 12(3/0).
// - (d8,PC,Xn): 10(2/0), long 14(3/0).
// - Index register size never changes the period count.
// - Byte/word move: reg-reg 4(1/0), (An)-to-Dn 8(2/0), Dn-to-(An) 8(1/1).
// - Move time includes opcode fetch, source reads and destination writes.
// - Report totals in clock periods with read and write cycle counts.
package ictm_pkg;

    localparam logic [5:0] BUS_PERIODS = 6'h04;
    localparam logic [1:0] PH_FIRST    = 2'h0;
    localparam logic [1:0] PH_LAST     = 2'(BUS_PERIODS - 6'h01);

    localparam logic [1:0] OP_EA   = 2'h0;
    localparam logic [1:0] OP_MOVE = 2'h1;

    localparam logic [3:0] EA_DREG    = 4'h0;
    localparam logic [3:0] EA_AREG    = 4'h1;
    localparam logic [3:0] EA_IND     = 4'h2;
    localparam logic [3:0] EA_POSTINC = 4'h3;
    localparam logic [3:0] EA_PREDEC  = 4'h4;
    localparam logic [3:0] EA_DISP    = 4'h5;
    localparam logic [3:0] EA_INDEX   = 4'h6;
    localparam logic [3:0] EA_ABSW    = 4'h7;
    localparam logic [3:0] EA_ABSL    = 4'h8;
    localparam logic [3:0] EA_PCDISP  = 4'h9;
    localparam logic [3:0] EA_PCINDEX = 4'ha;
    localparam logic [3:0] EA_IMM     = 4'hb;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_INT, ST_WRITE} ictm_state_t;

    typedef struct packed {
        logic [5:0] n;
        logic [2:0] r;
        logic [2:0] w;
        logic       ok;
    } ictm_cost_t;

    // Opcode fetch that every move pays
    localparam ictm_cost_t MOVE_BASE = '{n: 6'h04, r: 3'h1, w: 3'h0, ok: 1'b1};

    function automatic ictm_cost_t ictm_mk(input logic [5:0] n, input logic [2:0] r,
                                           input logic [2:0] w, input logic ok);
        ictm_cost_t c;
        c.n  = n;
        c.r  = r;
        c.w  = w;
        c.ok = ok;
        return c;
    endfunction

    // Address calculation table: reads only, write count always zero
    function automatic ictm_cost_t ictm_ea_cost(input logic [3:0] mode, input logic lng,
                                                input logic fetch);
        ictm_cost_t c;
        c = ictm_mk(6'h00, 3'h0, 3'h0, 1'b0);
        case (mode)
            EA_DREG, EA_AREG: c = ictm_mk(6'h00, 3'h0, 3'h0, fetch);
            EA_IND:     c = fetch ? (lng ? ictm_mk(6'h08, 3'h2, 3'h0, 1'b1) : ictm_mk(6'h04, 3'h1, 3'h0, 1'b1))
                                  : ictm_mk(6'h02, 3'h0, 3'h0, 1'b1);
            EA_POSTINC: c = fetch ? (lng ? ictm_mk(6'h08, 3'h2, 3'h0, 1'b1) : ictm_mk(6'h04, 3'h1, 3'h0, 1'b1))
                                  : ictm_mk(6'h04, 3'h0, 3'h0, 1'b1);
            EA_PREDEC:  c = fetch ? (lng ? ictm_mk(6'h0a, 3'h2, 3'h0, 1'b1) : ictm_mk(6'h06, 3'h1, 3'h0, 1'b1))
                                  : ictm_mk(6'h04, 3'h0, 3'h0, 1'b1);
            EA_DISP:    c = fetch ? (lng ? ictm_mk(6'h0c, 3'h3, 3'h0, 1'b1) : ictm_mk(6'h08, 3'h2, 3'h0, 1'b1))
                                  : (lng ? ictm_mk(6'h04, 3'h1, 3'h0, 1'b1) : ictm_mk(6'h04, 3'h0, 3'h0, 1'b1));
            EA_INDEX:   c = fetch ? (lng ? ictm_mk(6'h0e, 3'h3, 3'h0, 1'b1) : ictm_mk(6'h0a, 3'h2, 3'h0, 1'b1))
                                  : ictm_mk(6'h08, 3'h1, 3'h0, 1'b1);
            EA_ABSW:    c = fetch ? (lng ? ictm_mk(6'h0c, 3'h3, 3'h0, 1'b1) : ictm_mk(6'h08, 3'h2, 3'h0, 1'b1))
                                  : ictm_mk(6'h04, 3'h1, 3'h0, 1'b1);
            EA_ABSL:    c = fetch ? (lng ? ictm_mk(6'h10, 3'h4, 3'h0, 1'b1) : ictm_mk(6'h0c, 3'h3, 3'h0, 1'b1))
                                  : ictm_mk(6'h08, 3'h2, 3'h0, 1'b1);
            EA_PCDISP:  c = lng ? ictm_mk(6'h0c, 3'h3, 3'h0, fetch) : ictm_mk(6'h08, 3'h2, 3'h0, fetch);
            EA_PCINDEX: c = lng ? ictm_mk(6'h0e, 3'h3, 3'h0, fetch) : ictm_mk(6'h0a, 3'h2, 3'h0, fetch);
            EA_IMM:     c = lng ? ictm_mk(6'h08, 3'h2, 3'h0, fetch) : ictm_mk(6'h04, 3'h1, 3'h0, fetch);
            default:    c = ictm_mk(6'h00, 3'h0, 3'h0, 1'b0);
        endcase
        return c;
    endfunction

    // Byte/word move destination: extension reads plus the operand write for memory destinations
    function automatic ictm_cost_t ictm_dst_cost(input logic [3:0] mode);
        ictm_cost_t c;
        case (mode)
            EA_DREG, EA_AREG:             c = ictm_mk(6'h00, 3'h0, 3'h0, 1'b1);
            EA_IND, EA_POSTINC, EA_PREDEC: c = ictm_mk(6'h04, 3'h0, 3'h1, 1'b1);
            EA_DISP, EA_ABSW:             c = ictm_mk(6'h08, 3'h1, 3'h1, 1'b1);
            EA_INDEX:                     c = ictm_mk(6'h0a, 3'h1, 3'h1, 1'b1);
            EA_ABSL:                      c = ictm_mk(6'h0c, 3'h2, 3'h1, 1'b1);
            default:                      c = ictm_mk(6'h00, 3'h0, 3'h0, 1'b0);
        endcase
        return c;
    endfunction

endpackage

// *** core/ictm_core.sv ***
module ictm_core
    import ictm_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             start,
    input  wire logic [1:0]       op,
    input  wire logic [3:0]       src_mode,
    input  wire logic [3:0]       dst_mode,
    input  wire logic             is_long,
    input  wire logic             fetch,
    input  wire logic             mem_ack_n,
    output logic                  busy,
    output logic                  bus_rd,
    output logic                  bus_wr,
    output logic                  bus_idle,
    output logic                  done,
    output logic                  cmd_err,
    output logic [5:0]            nom_periods,
    output logic [2:0]            nom_reads,
    output logic [2:0]            nom_writes,
    output logic [CNT_W-1:0]      total_periods,
    output logic [CNT_W-1:0]      wait_states,
    output logic [2:0]            reads_done,
    output logic [2:0]            writes_done,
    output logic [5:0]            idle_periods
);

    generate
        if (CNT_W < 8) begin : g_chk
            $error("ictm_core: CNT_W must be at least 8");
        end
    endgenerate

    typedef struct packed {
        ictm_state_t      st;
        logic [1:0]       ph;
        logic [2:0]       rd_left;
        logic [5:0]       int_left;
        logic [2:0]       wr_left;
        logic             is_ea;
        logic [5:0]       nom_n;
        logic [2:0]       nom_r;
        logic [2:0]       nom_w;
        logic [CNT_W-1:0] tot;
        logic [CNT_W-1:0] waits;
        logic [2:0]       rds;
        logic [2:0]       wrs;
        logic [5:0]       idle_cnt;
        logic             done;
        logic             err;
        logic [2:0]       sync;
        logic             rdy;
    } ictm_regs_t;

    ictm_regs_t q_reg;
    ictm_regs_t q_next;
    ictm_cost_t cost;
    ictm_cost_t src_c;
    ictm_cost_t dst_c;
    logic       go;
    logic [5:0] idle_nom;

    ////////////////////////////////////////////////////////////////////////////

    // Reads first, then internal work, then writes
    function automatic ictm_state_t ictm_pick(input logic [2:0] r, input logic [5:0] i,
                                              input logic [2:0] w);
        if (r != 3'h0) begin
            return ST_READ;
        end else if (i != 6'h00) begin
            return ST_INT;
        end else if (w != 3'h0) begin
            return ST_WRITE;
        end
        return ST_IDLE;
    endfunction

    assign go = start && (q_reg.st == ST_IDLE);

    // Index size is not an input: the tables never depend on it
    always_comb begin
        src_c = ictm_ea_cost(src_mode, is_long, (op == OP_MOVE) ? 1'b1 : fetch);
        dst_c = ictm_dst_cost(dst_mode);
        cost  = src_c;
        if (op == OP_MOVE) begin
            cost.n  = MOVE_BASE.n + src_c.n + dst_c.n;
            cost.r  = MOVE_BASE.r + src_c.r + dst_c.r;
            cost.w  = dst_c.w;
            // Long moves are outside this model
            cost.ok = src_c.ok && dst_c.ok && !is_long;
        end else if (op == OP_EA) begin
            cost.w = 3'h0;
        end else begin
            cost.ok = 1'b0;
        end
        idle_nom = cost.n - 6'(BUS_PERIODS * 6'({3'h0, cost.r} + {3'h0, cost.w}));
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        q_next      = q_reg;
        q_next.done = 1'b0;
        q_next.sync = {q_reg.sync[1:0], ~mem_ack_n};
        // Acknowledge counts only once two stages agree
        if (q_reg.sync[1] == q_reg.sync[2]) begin
            q_next.rdy = q_reg.sync[2];
        end
        if (q_reg.st != ST_IDLE) begin
            q_next.tot = q_reg.tot + 1'b1;
        end
        case (q_reg.st)
            ST_IDLE: begin
                if (go) begin
                    q_next.err = !cost.ok;
                    if (cost.ok) begin
                        q_next.nom_n    = cost.n;
                        q_next.nom_r    = cost.r;
                        q_next.nom_w    = cost.w;
                        q_next.rd_left  = cost.r;
                        q_next.wr_left  = cost.w;
                        q_next.int_left = idle_nom;
                        q_next.is_ea    = (op == OP_EA);
                        q_next.tot      = '0;
                        q_next.waits    = '0;
                        q_next.rds      = 3'h0;
                        q_next.wrs      = 3'h0;
                        q_next.idle_cnt = 6'h00;
                        q_next.ph       = PH_FIRST;
                        q_next.st       = ictm_pick(cost.r, idle_nom, cost.w);
                        q_next.done     = (ictm_pick(cost.r, idle_nom, cost.w) == ST_IDLE);
                    end
                end
            end
            ST_READ, ST_WRITE: begin
                if (q_reg.ph != PH_LAST) begin
                    q_next.ph = q_reg.ph + 2'h1;
                end else if (!q_reg.rdy) begin
                    q_next.waits = q_reg.waits + 1'b1;
                end else begin
                    q_next.ph = PH_FIRST;
                    if (q_reg.st == ST_READ) begin
                        q_next.rd_left = q_reg.rd_left - 3'h1;
                        q_next.rds     = q_reg.rds + 3'h1;
                        q_next.st      = ictm_pick(q_reg.rd_left - 3'h1, q_reg.int_left, q_reg.wr_left);
                    end else begin
                        q_next.wr_left = q_reg.wr_left - 3'h1;
                        q_next.wrs     = q_reg.wrs + 3'h1;
                        q_next.st      = ictm_pick(3'h0, 6'h00, q_reg.wr_left - 3'h1);
                    end
                    q_next.done = (q_next.st == ST_IDLE);
                end
            end
            ST_INT: begin
                q_next.int_left = q_reg.int_left - 6'h01;
                q_next.idle_cnt = q_reg.idle_cnt + 6'h01;
                q_next.st       = ictm_pick(3'h0, q_reg.int_left - 6'h01, q_reg.wr_left);
                q_next.done     = (q_next.st == ST_IDLE);
            end
            default: begin
                q_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign busy          = (q_reg.st != ST_IDLE);
    assign bus_rd        = (q_reg.st == ST_READ);
    assign bus_wr        = (q_reg.st == ST_WRITE);
    assign bus_idle      = (q_reg.st == ST_INT);
    assign done          = q_reg.done;
    assign cmd_err       = q_reg.err;
    assign nom_periods   = q_reg.nom_n;
    assign nom_reads     = q_reg.nom_r;
    assign nom_writes    = q_reg.nom_w;
    assign total_periods = q_reg.tot;
    assign wait_states   = q_reg.waits;
    assign reads_done    = q_reg.rds;
    assign writes_done   = q_reg.wrs;
    assign idle_periods  = q_reg.idle_cnt;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence bus_open_s;
        (bus_rd || bus_wr) && (q_reg.ph == PH_FIRST);
    endsequence

    sequence ea_go_s(logic [3:0] m, logic l, logic f);
        go && (op == OP_EA) && (src_mode == m) && (is_long == l) && (fetch == f);
    endsequence

    ea_no_write_a: assert property (busy && q_reg.is_ea |-> !bus_wr)
        else $error("write cycle during address calculation");

    cycle_len_a: assert property (bus_open_s |-> ##3 (q_reg.ph == PH_LAST) && (bus_rd || bus_wr))
        else $error("bus cycle does not reach its fourth period");

    wait_adds_a: assert property ((bus_rd || bus_wr) && (q_reg.ph == PH_LAST) && !q_reg.rdy
        |=> (q_reg.ph == PH_LAST) && (q_reg.waits == $past(q_reg.waits) + 1'b1)
            && (q_reg.tot == $past(q_reg.tot) + 1'b1))
        else $error("wait state not counted");

    total_sum_a: assert property (done |-> q_reg.tot == CNT_W'(q_reg.nom_n) + q_reg.waits)
        else $error("total periods differ from nominal plus waits");

    counts_match_a: assert property (done |-> (reads_done == nom_reads) && (writes_done == nom_writes))
        else $error("read or write count mismatch");

    idle_calc_a: assert property (done |-> idle_periods
        == 6'(nom_periods - BUS_PERIODS * 6'({3'h0, nom_reads} + {3'h0, nom_writes})))
        else $error("idle periods mismatch");

    ind_cost_a: assert property (ea_go_s(EA_IND, 1'b0, 1'b1) |=> ##3 bus_rd
        && (nom_periods == 6'h04) && (nom_reads == 3'h1))
        else $error("register indirect cost wrong");

    predec_cost_a: assert property (ea_go_s(EA_PREDEC, 1'b1, 1'b1)
        |=> (nom_periods == 6'h0a) && (nom_reads == 3'h2))
        else $error("predecrement cost wrong");

    disp_cost_a: assert property (ea_go_s(EA_DISP, 1'b1, 1'b0)
        |=> (nom_periods == 6'h04) && (nom_reads == 3'h1))
        else $error("displacement no-fetch cost wrong");

    index_cost_a: assert property (ea_go_s(EA_INDEX, 1'b0, 1'b1)
        |=> (nom_periods == 6'h0a) && (nom_reads == 3'h2))
        else $error("indexed cost wrong");

    pc_cost_a: assert property (ea_go_s(EA_PCINDEX, 1'b1, 1'b1)
        |=> (nom_periods == 6'h0e) && (nom_reads == 3'h3))
        else $error("pc indexed cost wrong");

    pcdisp_cost_a: assert property (ea_go_s(EA_PCDISP, 1'b0, 1'b1)
        |=> (nom_periods == 6'h08) && (nom_reads == 3'h2))
        else $error("pc displacement cost wrong");

    move_cost_a: assert property (go && (op == OP_MOVE) && !is_long && (src_mode == EA_DREG)
        && (dst_mode == EA_IND)
        |=> (nom_periods == 6'h08) && (nom_reads == 3'h1) && (nom_writes == 3'h1))
        else $error("move register to memory cost wrong");

endmodule

// *** bench/ictm_mem_model.sv ***
////////////////////////////////////////////////////////////////////////////////
module ictm_mem_model (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       bus_rd,
    input  wire logic       bus_wr,
    input  wire logic [7:0] stall,
    output logic            mem_ack_n
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       act_reg;
    logic [7:0] cnt_reg;

    // Ready strapped low between cycles, else the synchroniser would add waits at every start
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            act_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else begin
            act_reg <= bus_rd | bus_wr;
            if ((bus_rd | bus_wr) && !act_reg) begin
                cnt_reg <= stall;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end

    assign mem_ack_n = (cnt_reg != 8'h00);
endmodule

// *** bench/ictm_core_tb_top.sv ***
////////////////////////////////////////////////////////////////////////////////
module ictm_core_tb_top
    import ictm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys, rstn, start, is_long, fetch, mem_ack_n;
    logic [1:0]  op;
    logic [3:0]  src_mode, dst_mode;
    logic [7:0]  stall;
    logic        busy, bus_rd, bus_wr, bus_idle, done, cmd_err;
    logic [5:0]  nom_periods, idle_periods;
    logic [2:0]  nom_reads, nom_writes, reads_done, writes_done;
    logic [15:0] total_periods, wait_states;
    int          n_fail, n_checks, cyc, c_busy, c_rd, c_wr, c_idle;

    // Cost n*10+r per mode: fetch byte/word, no fetch, fetch long, no fetch long; -1 = no such form
    localparam int EA_T [12][4] = '{
        '{0, -1, 0, -1}, '{0, -1, 0, -1}, '{41, 20, 82, 20}, '{41, 40, 82, 40},
        '{61, 40, 102, 40}, '{82, 40, 123, 41}, '{102, 81, 143, 81}, '{82, 41, 123, 41},
        '{123, 82, 164, 82}, '{82, -1, 123, -1}, '{102, -1, 143, -1}, '{41, -1, 82, -1}};
    // Move destination extra n*10+r, one write for every memory destination
    localparam int DST_T [12] = '{0, 0, 40, 40, 40, 81, 101, 81, 122, -1, -1, -1};

    ictm_core #(.CNT_W(16)) u_ictm_core (
        .clk_sys(clk_sys), .rstn(rstn), .start(start), .op(op), .src_mode(src_mode),
        .dst_mode(dst_mode), .is_long(is_long), .fetch(fetch), .mem_ack_n(mem_ack_n),
        .busy(busy), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_idle(bus_idle), .done(done),
        .cmd_err(cmd_err), .nom_periods(nom_periods), .nom_reads(nom_reads),
        .nom_writes(nom_writes), .total_periods(total_periods), .wait_states(wait_states),
        .reads_done(reads_done), .writes_done(writes_done), .idle_periods(idle_periods));

    ictm_mem_model u_ictm_mem_model (
        .clk_sys(clk_sys), .rstn(rstn), .bus_rd(bus_rd), .bus_wr(bus_wr), .stall(stall),
        .mem_ack_n(mem_ack_n));

    always #20 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pre-edge values: each count is the number of cycles the output stood high
    always @(posedge clk_sys) begin
        cyc++;
        c_busy += int'(busy === 1'b1);
        c_rd += int'(bus_rd === 1'b1);
        c_wr += int'(bus_wr === 1'b1);
        c_idle += int'(bus_idle === 1'b1);
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end

    function automatic void ref_cost(input int o, s, d, l, f, output int n, r, w);
        int v;
        n = -1;
        r = 0;
        w = 0;
        v = (o == 0) ? EA_T[s][l * 2 + (f != 0 ? 0 : 1)] : EA_T[s][0];
        if (o == 0 && v >= 0) begin
            n = v / 10;
            r = v % 10;
        end else if (o == 1 && l == 0 && v >= 0 && DST_T[d] >= 0) begin
            n = 4 + v / 10 + DST_T[d] / 10;
            r = 1 + v % 10 + DST_T[d] % 10;
            w = int'(DST_T[d] > 0);
        end
    endfunction

    // Entered at a falling edge; a following run may start in the done cycle
    task automatic run(input int o, s, d, l, f, st);
        int n, r, w, k, bw;
        // A stall left over from the last run would add waits to a zero-stall run
        while (mem_ack_n !== 1'b0) @(negedge clk_sys);
        ref_cost(o, s, d, l, f, n, r, w);
        {op, src_mode, dst_mode, is_long, fetch, stall} = {2'(o), 4'(s), 4'(d), 1'(l), 1'(f), 8'(st)};
        start = 1'b1;
        {c_busy, c_rd, c_wr, c_idle} = '0;
        @(negedge clk_sys);
        if (n >= 2) begin
            src_mode = 4'($urandom_range(11)); // refused while busy
            @(negedge clk_sys);
        end
        start = 1'b0;
        for (k = 0; k < 400 && n >= 0 && done !== 1'b1; k++) @(negedge clk_sys);
        bw = c_rd + c_wr - 4 * (r + w);
        if (n < 0) begin
            chk_flag(cmd_err, 1'b1);
            chk_flag(busy, 1'b0);
        end else begin
            chk_flag(done, 1'b1);
            chk_flag(cmd_err, 1'b0);
            chk(nom_periods, n);
            chk(nom_reads, r);
            chk(nom_writes, w);
            chk(reads_done, r);
            chk(writes_done, w);
            chk(c_busy, n + bw);
            chk(total_periods, c_busy);
            chk(wait_states, bw);
            chk(c_idle, n - 4 * (r + w));
            chk(idle_periods, n - 4 * (r + w));
            if (w == 0) chk(c_wr, 0);
            if (st == 0) chk(wait_states, 0);
            // Synchroniser lag hides a stall from the bus cycle that raised it
            if (st >= 8 && r + w > 1) chk_flag(wait_states != 16'h0, 1'b1);
        end
        if (n <= 0) @(negedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        {rstn, start, op, src_mode, dst_mode, is_long, fetch, stall} = '0;
        {n_fail, n_checks, cyc} = '0;
        void'($urandom(87440));
        repeat (16) @(negedge clk_sys);
        rstn = 1'b1;
        // Let the ready synchroniser settle before the first bus cycle
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < 48; i++) run(0, i / 4, 0, (i / 2) % 2, i % 2, 0);
        $display("test ea_sweep done");
        for (int i = 0; i < 144; i++) run(1, i / 12, i % 12, 0, 1, 0);
        run(1, 2, 0, 1, 1, 0);
        run(2, 2, 2, 0, 1, 0);
        run(3, 0, 0, 0, 0, 0);
        $display("test move_sweep done");
        repeat (150) begin
            run($urandom_range(1), $urandom_range(11), $urandom_range(11), $urandom_range(1),
                $urandom_range(1), $urandom_range(12));
        end
        $display("test random_stall done");
        {op, src_mode, is_long, fetch, stall} = {OP_EA, EA_ABSL, 1'b1, 1'b1, 8'h00};
        start = 1'b1;
        repeat (3) @(negedge clk_sys);
        start = 1'b0;
        rstn = 1'b0;
        @(negedge clk_sys);
        chk({busy, bus_rd, bus_wr, bus_idle, done, total_periods, reads_done}, 32'h0);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        run(0, 10, 0, 0, 1, 0);
        $display("test mid_reset done");
        test_done();
    end
endmodule
